// File: rtl/erase_debounce.sv
`timescale 1ns/100ps
`default_nettype none
`include "lp_sys_defs.svh"
module erase_debounce #(
  parameter int THRESH_TICKS = `ERASE_THRESH_TICKS
) (
  input  wire logic mclk,        // System clock
  input  wire logic rst,         // Synchronous reset
  input  wire logic slow_tick,   // One pulse per slow clock period
  input  wire logic level_hi,    // Qualified pin level
  output logic      erase_pulse  // Erase request, one cycle
);
  localparam int CW = $clog2(THRESH_TICKS + 1);
  if (THRESH_TICKS < 1) begin : g_bad_thresh
    $error("erase_debounce: threshold too small");
  end
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          done_r;
  logic          done_nxt;
  logic          pulse_r;
  logic          pulse_nxt;
  always_comb begin
    cnt_nxt   = cnt_r;
    done_nxt  = done_r;
    pulse_nxt = 1'b0;
    if (!level_hi) begin
      cnt_nxt  = '0; // R21
      done_nxt = 1'b0;
    end else if (slow_tick && !done_r) begin
      if (cnt_r == CW'(THRESH_TICKS - 1)) begin
        done_nxt  = 1'b1; // R17
        pulse_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r   <= '0;
      done_r  <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
      pulse_r <= pulse_nxt;
    end
  end
  assign erase_pulse = pulse_r;
endmodule // erase_debounce
`default_nettype wire

// File: rtl/low_power_and_system_pin_control.sv
// Contract
// R01 - Wait-for-event with low power select set enters wait mode.
// R02 - Wait mode gates core, peripheral and memory clocks; power stays on.
// R03 - Wake from wait mode completes in under 10 microseconds.
// R04 - Wake lines 0..15 wake from wait only when enabled as fast startup.
// R05 - Clock alarms and USB wake also end wait-for-event.
// R06 - Software selects fast RC clock, sets select bit, then waits for event.
// R07 - Software should poll fast RC enable clear before continuing.
// R08 - Sleep mode stops only the core clock.
// R09 - Either wait instruction with select bit clear enters sleep.
// R10 - Sleep by interrupt-wait wakes on interrupt; by event-wait on event.
// R11 - Backup wake re-enables core then SRAM supply, skipping ones already on.
// R12 - Reset pin is bidirectional; driven low internally or pulled externally.
// R13 - Reset pin resets core and peripherals, not the backup region.
// R14 - Any external pulse length accepted; driven pulse has a minimum length.
// R15 - After reset the reset pin is an input, driven only on reset.
// R16 - Accepted erase returns flash contents to all ones.
// R17 - Erase pin debounced by slow clock; short highs ignored, long erase.
// R18 - Erase pin not GPIO at startup; GPIO output low never erases.
// R19 - Board holds erase pin low at startup when reused as GPIO.
// R20 - Test pin high selects test mode; low selects normal operation.
// R21 - One fixed debounce threshold; counter restarts when pin falls early.
`timescale 1ns/100ps
`default_nettype none
`include "lp_sys_defs.svh"
module low_power_and_system_pin_control #(
  parameter int WAKE_CYC   = `WAKE_STARTUP_CYC,
  parameter int PULSE_CYC  = `RESET_PULSE_CYC,
  parameter int ERASE_TICK = `ERASE_THRESH_TICKS
) (
  input  wire logic        mclk,                     // 40 MHz clock
  input  wire logic        rst,                      // Synchronous reset
  input  wire logic        psel,                     // APB select
  input  wire logic        penable,                  // APB enable
  input  wire logic        pwrite,                   // APB write
  input  wire logic [11:0] paddr,                    // APB address
  input  wire logic [31:0] pwdata,                   // APB write data
  output logic      [31:0] prdata,                   // APB read data
  output logic             pready,                   // APB ready
  output logic             pslverr,                  // APB error
  input  wire logic        wait_for_event_instr,     // Core executes event wait
  input  wire logic        wait_for_interrupt_instr, // Core executes interrupt wait
  input  wire logic        irq_pending,              // Core interrupt pending
  input  wire logic [15:0] wake_lines,               // External wake lines
  input  wire logic        rtc_alarm,                // Real-time clock alarm
  input  wire logic        real_time_timer_alarm,    // Timer alarm
  input  wire logic        usb_wake,                 // USB wake-up event
  output logic             core_clk_en,              // Core clock gate
  output logic             periph_clk_en,            // Peripheral clock gate
  output logic             mem_clk_en,               // Memory clock gate
  output logic             core_wake_event,          // Event to the core
  input  wire logic        backup_wake,              // Wake in backup mode
  input  wire logic        core_supply_on,           // Core supply status
  input  wire logic        sram_supply_on,           // SRAM supply status
  output logic             core_supply_en_req,       // Enable core supply
  output logic             sram_supply_en_req,       // Enable SRAM supply
  input  wire logic        reset_pin_n_in,           // Reset pin level
  output logic             reset_pin_n_out,          // Reset pin drive value
  output logic             reset_pin_n_oe,           // Reset pin drive enable
  output logic             sys_reset,                // Core and peripheral reset
  input  wire logic        slow_tick,                // Slow clock tick
  input  wire logic        erase_pin_in,             // Erase pin level
  output logic             erase_pin_out,            // Erase pin GPIO value
  output logic             erase_pin_oe,             // Erase pin GPIO enable
  output logic             flash_erase_req,          // Flash erase to all ones
  input  wire logic        test_mode_pin,            // Test pin level
  output logic             test_mode_sel             // Test mode selected
);
  // Wake must end inside the startup limit; the driven pulse must last eight cycles at least
  if (WAKE_CYC < 1 || WAKE_CYC > 398 || PULSE_CYC < 8 || PULSE_CYC > 65535) begin : g_bad_timing
    $error("low_power_and_system_pin_control: bad timing parameter");
  end

  lp_sys_pkg::power_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        by_wfi_r, by_wfi_nxt;
  logic        lps_r, lps_nxt;
  logic        frc_r, frc_nxt;
  logic [15:0] wake_en_r, wake_en_nxt;
  logic [15:0] rcnt_r, rcnt_nxt;
  logic        gpio_r, gpio_nxt;
  logic        gval_r, gval_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        core_sup_r, core_sup_nxt;
  logic        sram_sup_r, sram_sup_nxt;
  logic        erase_pulse;
  logic        wr;
  logic        event_wake;
  logic        pin_low;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign wr = psel && penable && pwrite;
  assign event_wake = (|(wake_lines & wake_en_r)) || rtc_alarm || real_time_timer_alarm || usb_wake; // R04 R05
  assign pin_low = !reset_pin_n_in && !reset_pin_n_oe;

  // Power state machine
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    by_wfi_nxt = by_wfi_r;
    case (st_r)
      lp_sys_pkg::ST_RUN: begin
        if (wait_for_event_instr && lps_r) begin
          st_nxt = lp_sys_pkg::ST_WAIT_SYNC; // R01
        end else if ((wait_for_event_instr || wait_for_interrupt_instr) && !lps_r) begin
          st_nxt     = lp_sys_pkg::ST_SLEEP; // R09
          by_wfi_nxt = wait_for_interrupt_instr && !wait_for_event_instr;
        end
      end
      lp_sys_pkg::ST_SLEEP: begin
        if (by_wfi_r ? irq_pending : (event_wake || irq_pending)) begin
          st_nxt = lp_sys_pkg::ST_RUN; // R10
        end
      end
      lp_sys_pkg::ST_WAIT_SYNC: begin
        st_nxt = lp_sys_pkg::ST_WAIT;
      end
      lp_sys_pkg::ST_WAIT: begin
        if (event_wake) begin
          st_nxt  = lp_sys_pkg::ST_WAKE;
          cnt_nxt = '0;
        end
      end
      lp_sys_pkg::ST_WAKE: begin
        if (cnt_r == 16'(WAKE_CYC - 1)) begin
          st_nxt = lp_sys_pkg::ST_RUN; // R03
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: st_nxt = lp_sys_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst || sys_reset) begin
      st_r     <= lp_sys_pkg::ST_RUN;
      cnt_r    <= 16'h0000;
      by_wfi_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      by_wfi_r <= by_wfi_nxt;
    end
  end

  // Clock gates: wait stops everything, sleep only the core
  assign core_clk_en     = (st_r == lp_sys_pkg::ST_RUN); // R08
  assign periph_clk_en   = !(st_r == lp_sys_pkg::ST_WAIT || st_r == lp_sys_pkg::ST_WAKE); // R02
  assign mem_clk_en      = periph_clk_en; // R02
  assign core_wake_event = (st_r == lp_sys_pkg::ST_WAKE) && (st_nxt == lp_sys_pkg::ST_RUN);

  // Backup wake supply sequence: core first, then SRAM
  always_comb begin
    core_sup_nxt = core_sup_r;
    sram_sup_nxt = sram_sup_r;
    if (backup_wake && !core_supply_on) begin
      core_sup_nxt = 1'b1; // R11
    end else if (core_supply_on) begin
      core_sup_nxt = 1'b0;
    end
    if (backup_wake && core_supply_on && !sram_supply_on) begin
      sram_sup_nxt = 1'b1; // R11
    end else if (sram_supply_on) begin
      sram_sup_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_sup_r <= 1'b0;
      sram_sup_r <= 1'b0;
    end else begin
      core_sup_r <= core_sup_nxt;
      sram_sup_r <= sram_sup_nxt;
    end
  end
  assign core_supply_en_req = core_sup_r;
  assign sram_supply_en_req = sram_sup_r;

  // Reset pin control and APB registers
  always_comb begin
    lps_nxt     = lps_r;
    frc_nxt     = frc_r;
    wake_en_nxt = wake_en_r;
    gpio_nxt    = gpio_r;
    gval_nxt    = gval_r;
    rcnt_nxt    = rcnt_r;
    rd_nxt      = 32'h0000_0000;
    if (rcnt_r != 16'h0000) begin
      rcnt_nxt = rcnt_r - 16'h0001; // R14
    end
    if (wr && hit(paddr, `OFF_FAST_STARTUP_MODE)) begin
      lps_nxt = pwdata[`BIT_LOW_POWER_SELECT];
      frc_nxt = pwdata[`BIT_FAST_RC_OSC_EN];
    end
    if (st_r == lp_sys_pkg::ST_WAIT_SYNC) begin
      frc_nxt = 1'b0; // R07
    end
    if (wr && hit(paddr, `OFF_WAKE_ENABLE)) begin
      wake_en_nxt = pwdata[15:0];
    end
    if (wr && hit(paddr, `OFF_RESET_CTRL) && pwdata[`BIT_RESET_REQUEST]) begin
      rcnt_nxt = 16'(PULSE_CYC); // R14
    end
    if (wr && hit(paddr, `OFF_ERASE_CTRL)) begin
      gpio_nxt = pwdata[`BIT_ERASE_AS_GPIO];
      gval_nxt = pwdata[`BIT_GPIO_OUT_VALUE];
    end
    if (psel && !pwrite) begin
      if (hit(paddr, `OFF_FAST_STARTUP_MODE)) begin
        rd_nxt = {30'h0, frc_r, lps_r};
      end else if (hit(paddr, `OFF_WAKE_ENABLE)) begin
        rd_nxt = {16'h0, wake_en_r};
      end else if (hit(paddr, `OFF_STATUS)) begin
        rd_nxt = {26'h0, test_mode_sel, rcnt_r != 16'h0000, st_r, core_clk_en};
      end else if (hit(paddr, `OFF_ERASE_CTRL)) begin
        rd_nxt = {30'h0, gval_r, gpio_r};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lps_r     <= 1'(`RST_FAST_STARTUP_MODE >> `BIT_LOW_POWER_SELECT);
      frc_r     <= 1'(`RST_FAST_STARTUP_MODE >> `BIT_FAST_RC_OSC_EN);
      wake_en_r <= `RST_WAKE_ENABLE;
      gpio_r    <= 1'b0; // R18
      gval_r    <= 1'b0;
      rcnt_r    <= 16'h0000; // R15
      rd_r      <= 32'h0000_0000;
    end else begin
      lps_r     <= lps_nxt;
      frc_r     <= frc_nxt;
      wake_en_r <= wake_en_nxt;
      gpio_r    <= gpio_nxt;
      gval_r    <= gval_nxt;
      rcnt_r    <= rcnt_nxt;
      rd_r      <= rd_nxt;
    end
  end

  assign prdata          = rd_r;
  assign pready          = psel && penable;
  assign pslverr         = psel && penable && !(hit(paddr, `OFF_FAST_STARTUP_MODE) || hit(paddr, `OFF_WAKE_ENABLE)
                           || hit(paddr, `OFF_STATUS) || hit(paddr, `OFF_RESET_CTRL) || hit(paddr, `OFF_ERASE_CTRL));
  assign reset_pin_n_oe  = (rcnt_r != 16'h0000); // R12 R15
  assign reset_pin_n_out = 1'b0; // R12
  assign sys_reset       = (rcnt_r != 16'h0000) || pin_low; // R13

  // Erase pin: debounced only when not used as GPIO
  erase_debounce #(.THRESH_TICKS(ERASE_TICK)) u_deb (
    .mclk        (mclk),
    .rst         (rst),
    .slow_tick   (slow_tick),
    .level_hi    (erase_pin_in && !gpio_r), // R18
    .erase_pulse (erase_pulse)
  );
  assign flash_erase_req = erase_pulse; // R16
  assign erase_pin_oe    = gpio_r;
  assign erase_pin_out   = gval_r;
  assign test_mode_sel   = test_mode_pin; // R20

  a_wait_entry: assert property (@(posedge mclk) disable iff (rst)
    (st_r == lp_sys_pkg::ST_RUN && wait_for_event_instr && lps_r && !sys_reset) |=> ##1 (st_r == lp_sys_pkg::ST_WAIT))
    else $error("wait entry missed"); // R01
  a_wait_clocks: assert property (@(posedge mclk) disable iff (rst)
    (st_r == lp_sys_pkg::ST_WAIT) |-> (!core_clk_en && !periph_clk_en && !mem_clk_en))
    else $error("clocks run in wait"); // R02
  a_wake_time: assert property (@(posedge mclk) disable iff (rst || sys_reset)
    (st_r == lp_sys_pkg::ST_WAIT && event_wake) |=> ##[1:398] core_clk_en)
    else $error("wake too slow"); // R03
  a_sleep_periph: assert property (@(posedge mclk) disable iff (rst)
    (st_r == lp_sys_pkg::ST_SLEEP) |-> (!core_clk_en && periph_clk_en))
    else $error("sleep gating wrong"); // R08
  a_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
    (st_r == lp_sys_pkg::ST_RUN && wait_for_interrupt_instr && !lps_r && !sys_reset) |=> (st_r == lp_sys_pkg::ST_SLEEP))
    else $error("sleep entry missed"); // R09
  a_wfi_hold: assert property (@(posedge mclk) disable iff (rst || sys_reset)
    (st_r == lp_sys_pkg::ST_SLEEP && by_wfi_r && !irq_pending) |=> (st_r == lp_sys_pkg::ST_SLEEP))
    else $error("interrupt sleep left early"); // R10
  a_reset_pulse: assert property (@(posedge mclk) disable iff (rst)
    $rose(reset_pin_n_oe) |-> reset_pin_n_oe [*8])
    else $error("reset pulse too short"); // R14
  a_gpio_noerase: assert property (@(posedge mclk) disable iff (rst)
    (gpio_r && $past(gpio_r)) |-> !flash_erase_req)
    else $error("erase in gpio mode"); // R18
  a_wake_gated: assert property (@(posedge mclk) disable iff (rst || sys_reset)
    (st_r == lp_sys_pkg::ST_WAIT && !event_wake) |=> (st_r == lp_sys_pkg::ST_WAIT))
    else $error("wait left without enabled wake source"); // R04
  a_supply_order: assert property (@(posedge mclk) disable iff (rst)
    $rose(sram_supply_en_req) |-> $past(core_supply_on))
    else $error("sram supply before core supply"); // R11
  a_erase_level: assert property (@(posedge mclk) disable iff (rst)
    flash_erase_req |-> $past(erase_pin_in))
    else $error("erase without high pin"); // R17
  c_wait_cycle: cover property (@(posedge mclk) disable iff (rst) st_r == lp_sys_pkg::ST_WAKE ##1 core_clk_en);
  c_sleep_wfi: cover property (@(posedge mclk) disable iff (rst) st_r == lp_sys_pkg::ST_SLEEP && by_wfi_r);
  c_erase: cover property (@(posedge mclk) disable iff (rst) flash_erase_req);
  c_reset: cover property (@(posedge mclk) disable iff (rst) $rose(reset_pin_n_oe));
endmodule // low_power_and_system_pin_control
`default_nettype wire

// File: rtl/lp_sys_defs.svh
`ifndef LP_SYS_DEFS_SVH
`define LP_SYS_DEFS_SVH
// APB register byte offsets
`define OFF_FAST_STARTUP_MODE 12'h000
`define OFF_WAKE_ENABLE       12'h004
`define OFF_STATUS            12'h008
`define OFF_RESET_CTRL        12'h00C
`define OFF_ERASE_CTRL        12'h010
// Fields of the fast startup mode register
`define BIT_LOW_POWER_SELECT  0
`define BIT_FAST_RC_OSC_EN    1
// Fields of the reset control register
`define BIT_RESET_REQUEST     0
// Fields of the erase control register
`define BIT_ERASE_AS_GPIO     0
`define BIT_GPIO_OUT_VALUE    1
// Reset values
`define RST_FAST_STARTUP_MODE 2'h2
`define RST_WAKE_ENABLE       16'h0000
// Timing
`define CLK_PERIOD_NS         25
`define WAIT_STARTUP_US       10
`define WAKE_STARTUP_CYC      ((`WAIT_STARTUP_US * 1000) / `CLK_PERIOD_NS - 2)
`define RESET_PULSE_MIN_US    10
`define RESET_PULSE_CYC       ((`RESET_PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_CLK_HZ           32768
`define ERASE_IGNORE_MS       100
`define ERASE_ACCEPT_MS       220
`define ERASE_THRESH_MS       160
`define ERASE_THRESH_TICKS    ((`ERASE_THRESH_MS * `SLOW_CLK_HZ) / 1000)
`endif

// File: rtl/lp_sys_pkg.sv
`default_nettype none
package lp_sys_pkg;
  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_SLEEP     = 3'b100,
    ST_WAIT_SYNC = 3'b001,
    ST_WAIT      = 3'b011,
    ST_WAKE      = 3'b010
  } power_state_t;
endpackage
`default_nettype wire

// File: tb/lp_sys_partner.sv
`timescale 1ns/100ps
`default_nettype none
module lp_sys_partner (
  input  wire logic       mclk,               // System clock
  input  wire logic       reset_pin_n_out,    // Device reset drive value
  input  wire logic       reset_pin_n_oe,     // Device reset drive enable
  input  wire logic       ext_reset_n,        // Board pulls reset low
  input  wire logic       erase_pin_out,      // Device erase GPIO value
  input  wire logic       erase_pin_oe,       // Device erase GPIO enable
  input  wire logic       erase_drive,        // Board drives erase high
  input  wire logic       core_supply_en_req, // Core supply request
  input  wire logic       sram_supply_en_req, // SRAM supply request
  input  wire logic [1:0] cut_supply,         // Drop SRAM, core supply
  output wire logic       reset_pin_n_in,     // Reset wire level
  output wire logic       erase_pin_in,       // Erase wire level
  output var  logic       core_supply_on,     // Core supply status
  output var  logic       sram_supply_on      // SRAM supply status
);
  logic [1:0] core_dly_r = 2'h0;
  logic [1:0] sram_dly_r = 2'h0;
  logic       core_on_r  = 1'b0;
  logic       sram_on_r  = 1'b0;
  assign core_supply_on = core_on_r;
  assign sram_supply_on = sram_on_r;
  // Pull-up wins only when nobody pulls low
  assign reset_pin_n_in = !((reset_pin_n_oe && !reset_pin_n_out) || !ext_reset_n);
  // Pull-down when neither side drives
  assign erase_pin_in = erase_pin_oe ? erase_pin_out : erase_drive;
  // Supplies come up a few cycles after the request, like a slow regulator
  always @(posedge mclk) begin
    core_dly_r <= {core_dly_r[0], core_supply_en_req};
    sram_dly_r <= {sram_dly_r[0], sram_supply_en_req};
    if (cut_supply[0]) core_on_r <= 1'b0;
    else if (core_dly_r[1]) core_on_r <= 1'b1;
    if (cut_supply[1]) sram_on_r <= 1'b0;
    else if (sram_dly_r[1]) sram_on_r <= 1'b1;
  end
endmodule // lp_sys_partner
`default_nettype wire

// File: tb/test_low_power_and_system_pin_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_low_power_and_system_pin_control;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        wait_for_event_instr, wait_for_interrupt_instr, irq_pending;
  logic [15:0] wake_lines;
  logic        rtc_alarm, real_time_timer_alarm, usb_wake, backup_wake;
  logic        core_clk_en, periph_clk_en, mem_clk_en, core_wake_event;
  logic        core_supply_on, sram_supply_on, core_supply_en_req, sram_supply_en_req;
  logic        reset_pin_n_in, reset_pin_n_out, reset_pin_n_oe, sys_reset, ext_reset_n;
  logic        slow_tick, erase_pin_in, erase_pin_out, erase_pin_oe, flash_erase_req, erase_drive;
  logic        test_mode_pin, test_mode_sel, err;
  logic [1:0]  cut_supply;
  logic [2:0]  tick_cnt = 3'h0;
  int          mismatches = 0, checks = 0, erase_cnt = 0, wake_cnt = 0, n;

  low_power_and_system_pin_control #(.WAKE_CYC(5), .PULSE_CYC(10), .ERASE_TICK(4)) i_dut (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wait_for_event_instr, .wait_for_interrupt_instr, .irq_pending, .wake_lines,
    .rtc_alarm, .real_time_timer_alarm, .usb_wake, .core_clk_en, .periph_clk_en,
    .mem_clk_en, .core_wake_event, .backup_wake, .core_supply_on, .sram_supply_on,
    .core_supply_en_req, .sram_supply_en_req, .reset_pin_n_in, .reset_pin_n_out,
    .reset_pin_n_oe, .sys_reset, .slow_tick, .erase_pin_in, .erase_pin_out,
    .erase_pin_oe, .flash_erase_req, .test_mode_pin, .test_mode_sel);

  lp_sys_partner i_far (
    .mclk, .reset_pin_n_out, .reset_pin_n_oe, .ext_reset_n, .erase_pin_out,
    .erase_pin_oe, .erase_drive, .core_supply_en_req, .sram_supply_en_req,
    .cut_supply, .reset_pin_n_in, .erase_pin_in, .core_supply_on, .sram_supply_on);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Slow clock tick every eight system cycles
  always @(posedge mclk) begin
    tick_cnt  <= tick_cnt + 3'h1;
    slow_tick <= (tick_cnt == 3'h7);
  end
  always @(posedge mclk) begin
    if (rst) begin
      erase_cnt <= 0;
      wake_cnt  <= 0;
    end else begin
      if (flash_erase_req === 1'b1) erase_cnt <= erase_cnt + 1;
      if (core_wake_event === 1'b1) wake_cnt <= wake_cnt + 1;
    end
  end

  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
    chk(err, 1'b0);
  endtask

  task automatic pulse(input logic by_event);
    @(posedge mclk);
    if (by_event) wait_for_event_instr <= 1'b1;
    else wait_for_interrupt_instr <= 1'b1;
    @(posedge mclk);
    wait_for_event_instr     <= 1'b0;
    wait_for_interrupt_instr <= 1'b0;
  endtask

  task automatic wait_run;
    n = 0;
    while (core_clk_en !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 400, 1'b1);
    chk({core_clk_en, periph_clk_en, mem_clk_en}, 3'h7);
  endtask

  task automatic src(input int i, input logic v);
    case (i)
      0: wake_lines[15] <= v;
      1: rtc_alarm <= v;
      2: real_time_timer_alarm <= v;
      default: usb_wake <= v;
    endcase
  endtask

  task automatic erase_hi(input int k);
    erase_drive <= 1'b1;
    step(k);
    erase_drive <= 1'b0;
    step(40);
  endtask

  initial begin
    step(10000);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    wait_for_event_instr = 1'b0; wait_for_interrupt_instr = 1'b0; irq_pending = 1'b0;
    wake_lines = 16'h0000; rtc_alarm = 1'b0; real_time_timer_alarm = 1'b0; usb_wake = 1'b0;
    backup_wake = 1'b0; ext_reset_n = 1'b1; erase_drive = 1'b0; test_mode_pin = 1'b0;
    cut_supply = 2'h0;
    step(4);
    rst <= 1'b0;
    rd(12'h000, 32'h2);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h1);
    rd(12'h00C, 32'h0);
    chk({reset_pin_n_oe, erase_pin_oe, reset_pin_n_in}, 3'h1);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    rd(12'h008, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk({q[0], err}, 2'h1);
    apb(1'b1, 12'h004, 32'h0000_8000);
    rd(12'h004, 32'h0000_8000);
    // Sleep entered by interrupt wait ignores events
    apb(1'b1, 12'h000, 32'h2);
    pulse(1'b0);
    step(1);
    chk({core_clk_en, periph_clk_en, mem_clk_en}, 3'h3);
    usb_wake <= 1'b1;
    step(10);
    chk(core_clk_en, 1'b0);
    usb_wake    <= 1'b0;
    irq_pending <= 1'b1;
    wait_run();
    irq_pending <= 1'b0;
    pulse(1'b1);
    step(1);
    chk({core_clk_en, periph_clk_en, mem_clk_en}, 3'h3);
    rtc_alarm <= 1'b1;
    wait_run();
    rtc_alarm <= 1'b0;
    // Wait mode once per wake source
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, 32'h3);
      pulse(1'b1);
      step(2);
      chk({core_clk_en, periph_clk_en, mem_clk_en}, 3'h0);
      if (i == 0) begin
        wake_lines[3] <= 1'b1;
        step(20);
        chk(core_clk_en, 1'b0);
        wake_lines[3] <= 1'b0;
        step(1);
      end
      src(i, 1'b1);
      wait_run();
      src(i, 1'b0);
      rd(12'h000, 32'h1);
    end
    chk(wake_cnt, 32'h4);
    // Backup wake: core first, then SRAM, skipping supplies already on
    backup_wake <= 1'b1;
    step(2);
    chk({core_supply_en_req, sram_supply_en_req}, 2'h2);
    n = 0;
    while (sram_supply_on !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    backup_wake <= 1'b0;
    step(2);
    chk({core_supply_en_req, sram_supply_en_req, core_supply_on}, 3'h1);
    cut_supply <= 2'h2;
    step(1);
    cut_supply  <= 2'h0;
    backup_wake <= 1'b1;
    step(2);
    chk({core_supply_en_req, sram_supply_en_req}, 2'h1);
    step(8);
    backup_wake <= 1'b0;
    // Erase debounce
    erase_hi(16);
    chk(erase_cnt, 32'h0);
    erase_drive <= 1'b1;
    step(24);
    erase_drive <= 1'b0;
    step(8);
    erase_hi(24);
    chk(erase_cnt, 32'h0);
    erase_hi(200);
    chk(erase_cnt, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    step(1);
    chk({erase_pin_oe, erase_pin_out}, 2'h2);
    erase_hi(200);
    chk(erase_cnt, 32'h1);
    apb(1'b1, 12'h010, 32'h3);
    step(1);
    chk({erase_pin_oe, erase_pin_out}, 2'h3);
    erase_hi(200);
    chk(erase_cnt, 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    test_mode_pin <= 1'b1;
    rd(12'h008, 32'h21);
    chk(test_mode_sel, 1'b1);
    test_mode_pin <= 1'b0;
    // Driven reset pulse, then an external one
    apb(1'b1, 12'h00C, 32'h1);
    n = 0;
    while (reset_pin_n_oe !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk({sys_reset, reset_pin_n_in}, 2'h2);
    n = 0;
    while (reset_pin_n_oe === 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk(n, 32'h0000_000A);
    chk({reset_pin_n_oe, reset_pin_n_in}, 2'h1);
    ext_reset_n <= 1'b0;
    step(3);
    chk({sys_reset, reset_pin_n_oe, core_supply_on}, 3'h5);
    ext_reset_n <= 1'b1;
    step(3);
    chk({sys_reset, core_clk_en}, 2'h1);
    give_verdict();
  end
endmodule // test_low_power_and_system_pin_control
`default_nettype wire
